// ### rtl/sgcsr_top.sv
// apb register bank for two serial-if channels
// Notes on behaviour
// - writing one to soft reset clears the channel at once; reads zero.
// - txrx reset bit holds tx and rx in reset until written zero.
// - master mode takes speed and duplex from the local word.
// - loopback bit clocks rx from the tx clock.
// - writing one then zero to restart restarts negotiation.
// - negotiation runs only while the enable bit is one.
// - lock status follows the lock pin.
// - done bit is one after negotiation, gated by lock.
// - fault bit flags half duplex gigabit, gated by lock.
// - link bit shows link up, gated by lock.
// - 16-bit local word is read/write, upper bits read zero.
// - mac word: link, ack, 0, duplex, speed, zeros, one.
// - phy word: only ack bit and bit zero set.
// - partner word is read only at its own offset.
// - two identical, separately addressed channels.
// - id register holds code, rtl, major and minor revisions.
// - partner word reads valid only once negotiation is done.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sgcsr_defs.svh"
module sgcsr_top
    import sgcsr_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`SGCSR_AW-1:0]   paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [1:0]             lock_pin,
    input  wire logic [1:0]             rx_cfg_valid,
    input  wire logic [1:0][15:0]       rx_cfg_word,
    output logic      [1:0]             soft_reset_pulse,
    output logic      [1:0]             txrx_reset,
    output logic      [1:0]             loopback_en,
    output logic      [1:0]             neg_enable,
    output logic      [1:0]             neg_restart_pulse,
    output logic      [1:0][15:0]       tx_cfg_word,
    output logic      [1:0][1:0]        link_speed,
    output logic      [1:0]             link_full_duplex,
    output logic      [1:0]             link_up
);
    localparam int NCH = `SGCSR_NCH;

    // per-channel control state
    logic [NCH-1:0]       soft_r;
    logic [NCH-1:0]       txrx_r;
    logic [NCH-1:0]       neg_en_r;
    logic [NCH-1:0]       restart_r;
    logic [NCH-1:0]       restart_pls_r;
    logic [NCH-1:0]       loop_r;
    logic [NCH-1:0]       master_r;
    sgcsr_word_t          adv_r [NCH];

    // status gathered back from the channel logic
    logic [NCH-1:0]       lock_s;
    logic [NCH-1:0]       done_s;
    logic [NCH-1:0]       fault_s;
    logic [NCH-1:0]       link_s;
    sgcsr_word_t          lp_s  [NCH];

    // bus side
    logic                 pready_r;
    logic                 pslverr_r;
    logic [31:0]          prdata_r;
    logic                 setup;
    logic                 wr_en;
    logic                 ch_sel;
    logic [6:0]           off;
    logic [31:0]          rd_word;
    logic                 dec_err;

    // one strobe per register, shared by the read decode and the per-channel write strobes
    logic                 hit_id;
    logic                 hit_rst;
    logic                 hit_ctl;
    logic                 hit_sts;
    logic                 hit_adv;
    logic                 hit_lp;
    logic [NCH-1:0]       wr_ch;
    logic [NCH-1:0]       wr_rst;
    logic [NCH-1:0]       wr_soft;
    logic [NCH-1:0]       wr_ctl;
    logic [NCH-1:0]       wr_adv;

    assign ch_sel = paddr[`SGCSR_CH_BIT];
    assign off    = paddr[6:0];

    // setup phase seen once; pready then rises for the access phase
    assign setup  = psel && !penable && !pready_r;
    assign wr_en  = psel && penable && pready_r && pwrite;

    // offset decode; anything unlisted is a hole in the map
    always_comb begin
        hit_id  = 1'b0;
        hit_rst = 1'b0;
        hit_ctl = 1'b0;
        hit_sts = 1'b0;
        hit_adv = 1'b0;
        hit_lp  = 1'b0;
        if (off == `SGCSR_OFF_ID) begin
            hit_id = 1'b1;
        end else if (off == `SGCSR_OFF_RST) begin
            hit_rst = 1'b1;
        end else if (off == `SGCSR_OFF_CTL) begin
            hit_ctl = 1'b1;
        end else if (off == `SGCSR_OFF_STS) begin
            hit_sts = 1'b1;
        end else if (off == `SGCSR_OFF_ADV) begin
            hit_adv = 1'b1;
        end else if (off == `SGCSR_OFF_LP) begin
            hit_lp = 1'b1;
        end
    end

    // per-channel write strobes, qualified once; the restart pulse process decodes ctl writes itself
    always_comb begin
        wr_ch   = '0;
        wr_rst  = '0;
        wr_soft = '0;
        wr_ctl  = '0;
        wr_adv  = '0;
        for (int i = 0; i < NCH; i++) begin
            wr_ch[i]   = wr_en && ch_sel == i[0];
            wr_rst[i]  = wr_ch[i] && hit_rst;
            wr_soft[i] = wr_rst[i] && pwdata[`SGCSR_RST_SOFT];
            wr_ctl[i]  = wr_ch[i] && hit_ctl;
            wr_adv[i]  = wr_ch[i] && hit_adv;
        end
    end

    // read decode for the addressed channel
    always_comb begin
        rd_word = 32'h0000_0000;
        dec_err = 1'b0;
        if (hit_id) begin
            rd_word = {`SGCSR_ID_CODE, `SGCSR_RTL_REV,
                       `SGCSR_MAJ_REV, `SGCSR_MIN_REV};
        end else if (hit_rst) begin
            // soft reset bit never reads back
            rd_word[`SGCSR_RST_SOFT] = 1'b0;
            rd_word[`SGCSR_RST_TXRX] = txrx_r[ch_sel];
        end else if (hit_ctl) begin
            rd_word[`SGCSR_CTL_NEG_EN]  = neg_en_r[ch_sel];
            rd_word[`SGCSR_CTL_RESTART] = restart_r[ch_sel];
            rd_word[`SGCSR_CTL_LOOP]    = loop_r[ch_sel];
            rd_word[`SGCSR_CTL_MASTER]  = master_r[ch_sel];
        end else if (hit_sts) begin
            // flags lag lock by a cycle, so gate them here too
            rd_word[`SGCSR_STS_LOCK]  = lock_s[ch_sel];
            rd_word[`SGCSR_STS_DONE]  = done_s[ch_sel];
            rd_word[`SGCSR_STS_FAULT] = fault_s[ch_sel] &&
                                        lock_s[ch_sel];
            rd_word[`SGCSR_STS_LINK]  = link_s[ch_sel] &&
                                        lock_s[ch_sel];
        end else if (hit_adv) begin
            rd_word[15:0] = adv_r[ch_sel];
        end else if (hit_lp) begin
            // stale partner words are hidden until negotiation ends
            if (done_s[ch_sel])
                rd_word[15:0] = lp_s[ch_sel];
        end else begin
            dec_err = 1'b1;
        end
    end

    // apb answer: no wait states, outputs straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r <= setup;
            if (setup) begin
                pslverr_r <= dec_err;
                prdata_r  <= pwrite ? 32'h0000_0000 : rd_word;
            end else if (!psel) begin
                pslverr_r <= 1'b0;
            end
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // soft bit is only a one-cycle pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                soft_r[i] <= wr_soft[i];
            end
        end
    end

    // hold level stays until software writes zero or sets the soft reset bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txrx_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_rst[i])
                    txrx_r[i] <= pwdata[`SGCSR_RST_TXRX] &&
                                 !pwdata[`SGCSR_RST_SOFT];
            end
        end
    end

    // negotiation enable; a soft reset write clears it on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_en_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_soft[i])
                    neg_en_r[i] <= 1'b0;
                else if (wr_ctl[i])
                    neg_en_r[i] <= pwdata[`SGCSR_CTL_NEG_EN];
            end
        end
    end

    // restart level, kept so that its falling step can be seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_soft[i])
                    restart_r[i] <= 1'b0;
                else if (wr_ctl[i])
                    restart_r[i] <= pwdata[`SGCSR_CTL_RESTART];
            end
        end
    end

    // internal loopback select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_soft[i])
                    loop_r[i] <= 1'b0;
                else if (wr_ctl[i])
                    loop_r[i] <= pwdata[`SGCSR_CTL_LOOP];
            end
        end
    end

    // master select: resolve speed and duplex from the local word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_soft[i])
                    master_r[i] <= 1'b0;
                else if (wr_ctl[i])
                    master_r[i] <= pwdata[`SGCSR_CTL_MASTER];
            end
        end
    end

    // restart fires on the one-to-zero step of the control bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_pls_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                restart_pls_r[i] <= wr_en && ch_sel == i[0] &&
                    off == `SGCSR_OFF_CTL && restart_r[i] &&
                    !pwdata[`SGCSR_CTL_RESTART];
            end
        end
    end

    // local ability word; its link, duplex and speed fields drive resolution in master or forced mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++)
                adv_r[i] <= 16'h0000;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_soft[i])
                    adv_r[i] <= 16'h0000;
                else if (wr_adv[i])
                    adv_r[i] <= pwdata[15:0];
            end
        end
    end

    // one channel logic block per register set
    generate
        for (genvar g = 0; g < NCH; g++) begin : g_ch
            sgcsr_chan_if cif ();

            assign cif.soft_rst   = soft_r[g];
            assign cif.txrx_rst   = txrx_r[g];
            assign cif.neg_en     = neg_en_r[g];
            assign cif.restart    = restart_pls_r[g];
            assign cif.master     = master_r[g];
            assign cif.local_word = adv_r[g];

            sgcsr_chan u_chan (
                .pclk         (pclk),
                .presetn      (presetn),
                .lock_pin     (lock_pin[g]),
                .rx_cfg_valid (rx_cfg_valid[g]),
                .rx_cfg_word  (rx_cfg_word[g]),
                .cif          (cif.chan)
            );

            assign lock_s[g]  = cif.lock;
            assign done_s[g]  = cif.done;
            assign fault_s[g] = cif.fault;
            assign link_s[g]  = cif.link;
            assign lp_s[g]    = cif.partner_word;

            // link-facing controls, all flop-driven
            assign soft_reset_pulse[g]  = soft_r[g];
            assign txrx_reset[g]        = txrx_r[g];
            assign loopback_en[g]       = loop_r[g];
            assign neg_enable[g]        = neg_en_r[g];
            assign neg_restart_pulse[g] = restart_pls_r[g];
            assign tx_cfg_word[g]       = adv_r[g];
            assign link_speed[g]        = cif.speed;
            assign link_full_duplex[g]  = cif.fdx;
            assign link_up[g]           = cif.link;
        end
    endgenerate
endmodule // sgcsr_top
`default_nettype wire

// ### rtl/sgcsr_defs.svh
// offsets, field positions and fixed values of the serial-if registers
`ifndef SGCSR_DEFS_SVH
`define SGCSR_DEFS_SVH
`define SGCSR_NCH          2
`define SGCSR_AW           8
`define SGCSR_CH_BIT       7
`define SGCSR_OFF_ID       7'h00
`define SGCSR_OFF_RST      7'h04
`define SGCSR_OFF_CTL      7'h10
`define SGCSR_OFF_STS      7'h14
`define SGCSR_OFF_ADV      7'h18
`define SGCSR_OFF_LP       7'h20
`define SGCSR_RST_SOFT     0
`define SGCSR_RST_TXRX     1
`define SGCSR_CTL_NEG_EN   0
`define SGCSR_CTL_RESTART  1
`define SGCSR_CTL_LOOP     4
`define SGCSR_CTL_MASTER   5
`define SGCSR_STS_LINK     0
`define SGCSR_STS_FAULT    1
`define SGCSR_STS_DONE     2
`define SGCSR_STS_LOCK     4
`define SGCSR_CW_LINK      15
`define SGCSR_CW_ACK       14
`define SGCSR_CW_FDX       12
`define SGCSR_CW_SPD_HI    11
`define SGCSR_CW_SPD_LO    10
`define SGCSR_SPD_GIG      2'h2
`define SGCSR_ID_CODE      16'h5a3c
`define SGCSR_RTL_REV      5'h00
`define SGCSR_MAJ_REV      3'h1
`define SGCSR_MIN_REV      8'h01
`endif

// ### rtl/sgcsr_pkg.sv
// types shared by the serial-if register bank
package sgcsr_pkg;
    typedef enum logic [1:0] {NEG_OFF, NEG_WAIT, NEG_DONE} sgcsr_neg_t;
    typedef logic [15:0] sgcsr_word_t;
endpackage

// ### rtl/sgcsr_chan_if.sv
// control and status bundle between register bank and channel logic
`timescale 1ns/1ps
`default_nettype none
interface sgcsr_chan_if;
    import sgcsr_pkg::*;
    logic        soft_rst;
    logic        txrx_rst;
    logic        neg_en;
    logic        restart;
    logic        master;
    sgcsr_word_t local_word;
    logic        lock;
    logic        done;
    logic        fault;
    logic        link;
    sgcsr_word_t partner_word;
    logic [1:0]  speed;
    logic        fdx;
    modport regs (output soft_rst, txrx_rst, neg_en, restart, master,
                  local_word, input lock, done, fault, link,
                  partner_word, speed, fdx);
    modport chan (input soft_rst, txrx_rst, neg_en, restart, master,
                  local_word, output lock, done, fault, link,
                  partner_word, speed, fdx);
endinterface // sgcsr_chan_if
`default_nettype wire

// ### rtl/sgcsr_chan.sv
// per-channel lock synchroniser, negotiation tracker and resolution
`timescale 1ns/1ps
`default_nettype none
`include "sgcsr_defs.svh"
module sgcsr_chan
    import sgcsr_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    input  wire logic   lock_pin,
    input  wire logic   rx_cfg_valid,
    input  wire logic [15:0] rx_cfg_word,
    sgcsr_chan_if.chan  cif
);
    logic        lock_meta_r;
    logic        lock_r;
    sgcsr_neg_t  st_r;
    sgcsr_word_t lp_r;
    sgcsr_word_t res;
    logic        flt_r;
    logic        lnk_r;
    logic [1:0]  spd_r;
    logic        fdx_r;

    // two-stage synchroniser for the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_meta_r <= 1'b0;
            lock_r      <= 1'b0;
        end else begin
            lock_meta_r <= lock_pin;
            lock_r      <= lock_meta_r;
        end
    end

    // negotiation tracker, resets win over everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= NEG_OFF;
            lp_r <= '0;
        end else if (cif.soft_rst || cif.txrx_rst || !cif.neg_en) begin
            st_r <= NEG_OFF;
            if (cif.soft_rst)
                lp_r <= '0;
        end else if (cif.restart) begin
            st_r <= NEG_WAIT;
            lp_r <= '0;
        end else begin
            case (st_r)
                NEG_OFF: st_r <= NEG_WAIT;
                NEG_WAIT: begin
                    if (rx_cfg_valid && rx_cfg_word[`SGCSR_CW_ACK]) begin
                        st_r <= NEG_DONE;
                        lp_r <= rx_cfg_word;
                    end
                end
                default: st_r <= st_r;
            endcase
        end
    end

    // master or forced link resolves from the local word
    assign res = (cif.master || !cif.neg_en) ? cif.local_word : lp_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_r <= 2'h0;
            fdx_r <= 1'b0;
            flt_r <= 1'b0;
            lnk_r <= 1'b0;
        end else begin
            spd_r <= res[`SGCSR_CW_SPD_HI:`SGCSR_CW_SPD_LO];
            fdx_r <= res[`SGCSR_CW_FDX];
            // half duplex at gigabit raises the fault flag; the link is not held down
            flt_r <= lock_r && res[`SGCSR_CW_SPD_HI:`SGCSR_CW_SPD_LO] ==
                     `SGCSR_SPD_GIG && !res[`SGCSR_CW_FDX];
            lnk_r <= lock_r && !cif.txrx_rst && res[`SGCSR_CW_LINK] &&
                     (st_r == NEG_DONE || !cif.neg_en);
        end
    end

    assign cif.lock         = lock_r;
    assign cif.done         = lock_r && st_r == NEG_DONE;
    assign cif.fault        = flt_r;
    assign cif.link         = lnk_r;
    assign cif.partner_word = lp_r;
    assign cif.speed        = spd_r;
    assign cif.fdx          = fdx_r;
endmodule // sgcsr_chan
`default_nettype wire

// ### bench/sgcsr_props.sv
// concurrent checks on the serial-if register bank ports
`timescale 1ns/1ps
`default_nettype none
`include "sgcsr_defs.svh"
module sgcsr_props (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [`SGCSR_AW-1:0] paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [1:0]           soft_reset_pulse,
    input wire logic [1:0]           txrx_reset,
    input wire logic [1:0]           loopback_en,
    input wire logic [1:0]           neg_enable,
    input wire logic [1:0]           neg_restart_pulse,
    input wire logic [1:0][15:0]     tx_cfg_word
);
    localparam logic [31:0] IDW = {`SGCSR_ID_CODE, `SGCSR_RTL_REV,
                                   `SGCSR_MAJ_REV, `SGCSR_MIN_REV};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc, w_rst, w_ctl, w_adv;
    // completed transfers; write checks watch channel 0 only to keep the checker small
    assign acc   = psel && penable && pready;
    assign w_rst = acc && pwrite && paddr == 8'h04;
    assign w_ctl = acc && pwrite && paddr == 8'h10;
    assign w_adv = acc && pwrite && paddr == 8'h18;

    soft_pulse_a: assert property (w_rst && pwdata[0] |=>
        soft_reset_pulse[0] ##1 !soft_reset_pulse[0])
        else $error("soft pulse");
    txrx_hold_a: assert property (w_rst && !pwdata[0] |=>
        txrx_reset[0] == $past(pwdata[1])) else $error("txrx hold");
    txrx_keep_a: assert property (txrx_reset[0] && !w_rst |=>
        txrx_reset[0]) else $error("txrx dropped");
    loop_follow_a: assert property (w_ctl |=>
        loopback_en[0] == $past(pwdata[4])) else $error("loopback");
    enable_follow_a: assert property (w_ctl |=>
        neg_enable[0] == $past(pwdata[0])) else $error("neg enable");
    restart_once_a: assert property (neg_restart_pulse[0] |->
        $past(w_ctl) ##1 !neg_restart_pulse[0]) else $error("restart");
    local_word_a: assert property (w_adv |=>
        {16'h0, tx_cfg_word[0]} == ($past(pwdata) & 32'h0000ffff))
        else $error("local word");
    id_read_a: assert property (acc && !pwrite && paddr[6:0] == 7'h00
        |-> prdata == IDW) else $error("id value");
    status_gate_a: assert property (
        acc && !pwrite && paddr[6:0] == 7'h14 |-> prdata[31:5] == 27'h0 &&
        !prdata[3] && (prdata[4] || prdata[2:0] == 3'h0))
        else $error("status gate");
    unmapped_err_a: assert property (acc && !(paddr[6:0] inside
        {7'h00, 7'h04, 7'h10, 7'h14, 7'h18, 7'h20}) |-> pslverr)
        else $error("unmapped offset");
    apb_wait_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("wait state");

    // main scenarios reached
    cover property (w_rst && pwdata[0]);
    cover property (neg_restart_pulse[0]);
    cover property (acc && pslverr);
endmodule // sgcsr_props

bind sgcsr_top sgcsr_props i_props (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .soft_reset_pulse,
    .txrx_reset, .loopback_en, .neg_enable, .neg_restart_pulse, .tx_cfg_word);
`default_nettype wire

// ### bench/sgcsr_peer.sv
// far-side link partner model sending received config words
`timescale 1ns/1ps
`default_nettype none
module sgcsr_peer (
    input  wire logic             pclk,
    output logic      [1:0]       rx_cfg_valid,
    output logic      [1:0][15:0] rx_cfg_word
);
    initial begin
        rx_cfg_valid = 2'h0;
        rx_cfg_word  = '0;
    end
    // gap cycles model a slow partner; idle lines invert so stale data fails
    task automatic send(input int ch, input logic [15:0] w, input int gap);
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        rx_cfg_valid[ch] <= 1'b1;
        rx_cfg_word[ch]  <= w;
        @(posedge pclk);
        rx_cfg_valid[ch] <= 1'b0;
        rx_cfg_word[ch]  <= ~w;
    endtask
endmodule // sgcsr_peer
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the serial-if register bank
`timescale 1ns/1ps
`default_nettype none
`include "sgcsr_defs.svh"
module tb_top;
    typedef struct {logic [7:0] a; logic [31:0] d, r; logic e;} sgcsr_row_t;
    localparam logic [31:0] IDW = {`SGCSR_ID_CODE, `SGCSR_RTL_REV,
                                   `SGCSR_MAJ_REV, `SGCSR_MIN_REV};
    logic             pclk = 1'b0, presetn = 1'b0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0, prdata, rd;
    logic             pready, pslverr, er;
    logic [1:0]       lock_pin = 2'h0, rx_cfg_valid, soft_reset_pulse;
    logic [1:0]       txrx_reset, loopback_en, neg_enable, neg_restart_pulse;
    logic [1:0]       link_full_duplex, link_up;
    logic [1:0][15:0] rx_cfg_word, tx_cfg_word;
    logic [1:0][1:0]  link_speed;
    int               n_mismatch = 0, comparisons = 0, n_soft = 0, n_rst = 0;
    // write then read back; e marks an offset that must be refused
    sgcsr_row_t rows [9] = '{
        '{8'h18, 32'hffffffff, 32'h0000ffff, 1'b0},
        '{8'h98, 32'h12345678, 32'h00005678, 1'b0},
        '{8'h80, 32'hffffffff, IDW, 1'b0},
        '{8'h20, 32'hffffffff, 32'h0, 1'b0},
        '{8'h14, 32'hffffffff, 32'h0, 1'b0},
        '{8'h04, 32'hfffffffe, 32'h2, 1'b0},
        '{8'h04, 32'h0, 32'h0, 1'b0},
        '{8'h10, 32'hffffffc0, 32'h0, 1'b0},
        '{8'h08, 32'h1, 32'h0, 1'b1}};

    sgcsr_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .lock_pin, .rx_cfg_valid,
        .rx_cfg_word, .soft_reset_pulse, .txrx_reset, .loopback_en,
        .neg_enable, .neg_restart_pulse, .tx_cfg_word, .link_speed,
        .link_full_duplex, .link_up);
    sgcsr_peer i_peer (.pclk, .rx_cfg_valid, .rx_cfg_word);

    always #50 pclk = ~pclk;
    // pulses last one cycle, so count them as they pass
    always @(posedge pclk) begin
        n_soft += (soft_reset_pulse[0] === 1'b1);
        n_rst  += (neg_restart_pulse[0] === 1'b1);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the watchdog ends a wait that never completes
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk); // let the landed write settle for the caller
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic stop_test;
        $display("counts: %0d mismatches, %0d comparisons", n_mismatch,
                 comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #1000000;
        n_mismatch++;
        stop_test;
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            chk({31'h0, er}, {31'h0, rows[i].e});
            apb(1'b0, rows[i].a, 32'h0);
            chk({31'h0, er}, {31'h0, rows[i].e});
            if (!rows[i].e) chk(rd, rows[i].r);
        end
        chk({tx_cfg_word[1], tx_cfg_word[0]}, 32'h5678ffff);
        $display("test rows done");
        // loopback change wrapped in the txrx hold
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h10, 32'h10);
        chk({28'h0, txrx_reset, loopback_en}, 32'h5);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h10, 32'h0);
        chk({28'h0, txrx_reset, loopback_en}, 32'h0);
        $display("test loopback done");
        // word ignored while disabled, then accepted
        lock_pin <= 2'h1;
        i_peer.send(0, 16'hd801, 2);
        rdc(8'h14, 32'h11);
        apb(1'b1, 8'h10, 32'h1);
        chk({30'h0, neg_enable}, 32'h1);
        i_peer.send(0, 16'hd801, 0);
        rdc(8'h14, 32'h15);
        rdc(8'h20, 32'h0000d801);
        chk({28'h0, link_speed[0], link_full_duplex[0], link_up[0]}, 32'hb);
        $display("test negotiation done");
        // restart, then a half duplex gigabit word from a slow partner
        apb(1'b1, 8'h10, 32'h3);
        apb(1'b1, 8'h10, 32'h1);
        rdc(8'h14, 32'h10);
        chk(32'(n_rst), 32'h1);
        i_peer.send(0, 16'hc801, 3);
        rdc(8'h14, 32'h17);
        // master takes speed and duplex from the local word
        apb(1'b1, 8'h18, 32'h1401);
        apb(1'b1, 8'h10, 32'h21);
        repeat (2) @(posedge pclk);
        chk({29'h0, link_speed[0], link_full_duplex[0]}, 32'h3);
        // lock loss hides the other status bits
        lock_pin <= 2'h0;
        repeat (3) @(posedge pclk);
        rdc(8'h14, 32'h0);
        $display("test status done");
        // soft reset clears channel 0 only
        apb(1'b1, 8'h04, 32'h1);
        rdc(8'h04, 32'h0);
        rdc(8'h10, 32'h0);
        rdc(8'h18, 32'h0);
        chk(32'(n_soft), 32'h1);
        rdc(8'h98, 32'h00005678);
        // second hardware reset in mid-run
        apb(1'b1, 8'h10, 32'h31);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h10, 32'h0);
        rdc(8'h98, 32'h0);
        $display("test resets done");
        stop_test;
    end
endmodule // tb_top
`default_nettype wire
